// File: tro_pkg.sv
// Shared constants and types for the tag read parallel output block
package tro_pkg;

	// APB register byte offsets
	localparam logic [7:0] TRO_CFG_OFF     = 8'h00;
	localparam logic [7:0] TRO_STATUS_OFF  = 8'h04;
	localparam logic [7:0] TRO_IRQ_STAT_OFF = 8'h08;
	localparam logic [7:0] TRO_IRQ_CLR_OFF = 8'h0c;
	localparam logic [7:0] TRO_IRQ_EN_OFF  = 8'h10;

	// Configuration register fields
	localparam int TRO_CFG_HOLD_LSB = 0;
	localparam int TRO_CFG_HOLD_W   = 16;
	localparam int TRO_CFG_CONT_BIT = 16;

	// Status register fields
	localparam int TRO_ST_STATE_LSB = 0;
	localparam int TRO_ST_NORMAL_BIT = 4;
	localparam int TRO_ST_ERROR_BIT = 5;
	localparam int TRO_ST_FIELD_BIT = 6;
	localparam int TRO_ST_DATA_LSB  = 8;

	// Interrupt bit positions
	localparam int TRO_IRQ_DONE_BIT = 0;
	localparam int TRO_IRQ_ERR_BIT  = 1;
	localparam int TRO_IRQ_W        = 2;

	// Reset values
	localparam logic [15:0] TRO_HOLD_RST = 16'h0064;
	localparam logic        TRO_CONT_RST = 1'b0;
	localparam logic [1:0]  TRO_IRQ_EN_RST = 2'h0;

	// Timing
	localparam int TRO_CLK_PERIOD_NS = 100;
	localparam int TRO_MS_NS         = 1000000;
	localparam int TRO_CYC_PER_MS    = TRO_MS_NS / TRO_CLK_PERIOD_NS;
	localparam logic [15:0] TRO_STROBE_DELAY_MS = 16'h0003;

	typedef enum logic [2:0] {
		ST_WAIT,
		ST_ACCESS,
		ST_DELAY,
		ST_NORMAL,
		ST_ERROR,
		ST_INHIBIT
	} tro_state_t;

endpackage

// File: tro_ms_timer.sv
// Millisecond timebase and one-shot interval timer
`timescale 1ns/1ps
module tro_ms_timer import tro_pkg::*; #(
	parameter int CYC_PER_MS = TRO_CYC_PER_MS
) (
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        start_i,
	input  wire logic        stop_i,
	input  wire logic [15:0] ms_i,
	output logic             done_o
);
	logic [31:0] cyc_r;
	logic [15:0] ms_r;
	logic [15:0] target_r;
	logic        run_r;
	wire         ms_tick_w = (cyc_r == 32'(CYC_PER_MS - 1));
	wire         last_ms_w = ((ms_r + 16'h0001) == target_r);

	// Done is combinational so the caller acts on the very edge it ends
	assign done_o = run_r && ms_tick_w && last_ms_w;

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			cyc_r    <= 32'h0;
			ms_r     <= 16'h0;
			target_r <= 16'h0;
			run_r    <= 1'b0;
		end else if (start_i) begin
			cyc_r    <= 32'h0;
			ms_r     <= 16'h0;
			target_r <= ms_i;
			run_r    <= 1'b1;
		end else if (stop_i || done_o) begin
			run_r <= 1'b0;
		end else if (run_r) begin
			cyc_r <= ms_tick_w ? 32'h0 : cyc_r + 32'h1;
			ms_r  <= ms_tick_w ? ms_r + 16'h0001 : ms_r;
		end
	end
endmodule // tro_ms_timer

// File: tro_read_out.sv
// Tag read sequencer with parallel host outputs and APB registers
// Notes on behaviour
// - After reset the block waits for a tag without any host command.
// - A tag entering the field starts an access that reads one byte.
// - The byte read is shown on the eight read data lines, one bit each.
// - Normal completion rises 3 ms after the byte appears on the lines.
// - Normal completion then stays high for the set hold time in ms.
// - Suppress clears normal completion at once, even in continuous hold.
// - The read data lines keep their value until the next read result.
// - Suppress or an access error forces all eight data lines to zero.
// - A tag leaving the field before the access ends is an access error.
// - An access error raises the error output for the set hold time.
// - The error output low means running and high means error.
// - Suppress clears the error output at once, even in continuous hold.
// - Suppress is advised for a parked tag; while high the field is off.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module tro_read_out import tro_pkg::*; #(
	parameter int CYC_PER_MS = TRO_CYC_PER_MS
) (
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tag_present_i,
	input  wire logic        tag_done_i,
	input  wire logic [7:0]  tag_byte_i,
	output logic             field_en_o,
	output logic             access_o,
	input  wire logic        suppress_i,
	output logic [7:0]       read_data_lines_o,
	output logic             normal_completion_output_o,
	output logic             error_o,
	output logic             irq_o
);
	tro_state_t  st_r;
	tro_state_t  st_nxt;
	logic [7:0]  data_r;
	logic        normal_r;
	logic        error_r;
	logic        tag_prev_r;
	logic [15:0] hold_r;
	logic        cont_r;
	logic [TRO_IRQ_W-1:0] irq_stat_r;
	logic [TRO_IRQ_W-1:0] irq_en_r;
	logic        tmr_done_w;

	// Register bus decode
	wire wr_w      = psel && penable && pwrite;
	wire hit_cfg_w = (paddr == TRO_CFG_OFF);
	wire hit_st_w  = (paddr == TRO_STATUS_OFF);
	wire hit_is_w  = (paddr == TRO_IRQ_STAT_OFF);
	wire hit_ic_w  = (paddr == TRO_IRQ_CLR_OFF);
	wire hit_ie_w  = (paddr == TRO_IRQ_EN_OFF);
	wire mapped_w  = hit_cfg_w | hit_st_w | hit_is_w | hit_ic_w | hit_ie_w;

	wire [31:0] cfg_rd_w = {15'h0, cont_r, hold_r};
	wire [31:0] st_rd_w  = {16'h0, data_r, 1'b0, field_en_o, error_r,
		normal_r, 1'b0, st_r};

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped_w;
	assign prdata  = hit_cfg_w ? cfg_rd_w :
		hit_st_w ? st_rd_w :
		hit_is_w ? {30'h0, irq_stat_r} :
		hit_ie_w ? {30'h0, irq_en_r} : 32'h0;

	// Sequencer events
	wire tag_rise_w  = tag_present_i && !tag_prev_r;
	wire access_ok_w = (st_r == ST_ACCESS) && tag_done_i;
	wire access_err_w = (st_r == ST_ACCESS) && !tag_done_i &&
		!tag_present_i;
	wire hold_st_w   = (st_r == ST_NORMAL) || (st_r == ST_ERROR);
	wire [15:0] hold_eff_w = (hold_r == 16'h0) ? 16'h0001 : hold_r;

	// Timer starts: strobe delay after capture, hold after strobe or error
	wire tmr_start_w = !suppress_i && (access_ok_w || access_err_w ||
		((st_r == ST_DELAY) && tmr_done_w));
	wire [15:0] tmr_ms_w = access_ok_w ? TRO_STROBE_DELAY_MS :
		hold_eff_w;
	wire hold_end_w  = hold_st_w && tmr_done_w && !cont_r;

	tro_ms_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_timer (
		.core_clk_i(core_clk_i),
		.rstn_i    (rstn_i),
		.start_i   (tmr_start_w),
		.stop_i    (suppress_i),
		.ms_i      (tmr_ms_w),
		.done_o    (tmr_done_w)
	);

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_WAIT: begin
				if (tag_rise_w)
					st_nxt = ST_ACCESS;
			end
			ST_ACCESS: begin
				if (access_ok_w)
					st_nxt = ST_DELAY;
				else if (access_err_w)
					st_nxt = ST_ERROR;
			end
			ST_DELAY: begin
				if (tmr_done_w)
					st_nxt = ST_NORMAL;
			end
			ST_NORMAL, ST_ERROR: begin
				// A new tag replaces the result held so far
				if (tag_rise_w)
					st_nxt = ST_ACCESS;
				else if (hold_end_w)
					st_nxt = ST_WAIT;
			end
			ST_INHIBIT: begin
				st_nxt = ST_WAIT;
			end
			default: begin
				st_nxt = ST_WAIT;
			end
		endcase
		// Suppress overrides every state and aborts an access quietly
		if (suppress_i)
			st_nxt = ST_INHIBIT;
	end

	// Output qualifiers
	wire load_w  = !suppress_i && access_ok_w;
	wire clear_w = suppress_i || access_err_w;
	wire norm_set_w = !suppress_i && (st_r == ST_DELAY) && tmr_done_w;
	wire norm_clr_w = suppress_i || tag_rise_w ||
		((st_r == ST_NORMAL) && hold_end_w);
	wire err_set_w  = !suppress_i && access_err_w;
	wire err_clr_w  = suppress_i || tag_rise_w ||
		((st_r == ST_ERROR) && hold_end_w);

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			st_r       <= ST_WAIT;
			tag_prev_r <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			tag_prev_r <= tag_present_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i)
			data_r <= 8'h00;
		else if (clear_w)
			data_r <= 8'h00;
		else if (load_w)
			data_r <= tag_byte_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			normal_r <= 1'b0;
			error_r  <= 1'b0;
		end else begin
			normal_r <= norm_set_w | (normal_r & ~norm_clr_w);
			error_r  <= err_set_w | (error_r & ~err_clr_w);
		end
	end

	// Configuration and interrupt registers; a new event beats a clear
	wire [TRO_IRQ_W-1:0] irq_evt_w = {err_set_w, load_w};
	wire [TRO_IRQ_W-1:0] irq_clr_w = (wr_w && hit_ic_w) ?
		pwdata[TRO_IRQ_W-1:0] : {TRO_IRQ_W{1'b0}};

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			hold_r     <= TRO_HOLD_RST;
			cont_r     <= TRO_CONT_RST;
			irq_en_r   <= TRO_IRQ_EN_RST;
			irq_stat_r <= {TRO_IRQ_W{1'b0}};
		end else begin
			if (wr_w && hit_cfg_w) begin
				hold_r <= pwdata[TRO_CFG_HOLD_LSB +: TRO_CFG_HOLD_W];
				cont_r <= pwdata[TRO_CFG_CONT_BIT];
			end
			if (wr_w && hit_ie_w)
				irq_en_r <= pwdata[TRO_IRQ_W-1:0];
			irq_stat_r <= irq_evt_w | (irq_stat_r & ~irq_clr_w);
		end
	end

	assign read_data_lines_o          = data_r;
	assign normal_completion_output_o = normal_r;
	assign error_o                    = error_r;
	assign irq_o      = |(irq_stat_r & irq_en_r);
	assign access_o   = (st_r == ST_ACCESS);
	// Field stops the cycle suppress rises, to spare a parked tag's battery
	assign field_en_o = !suppress_i && (st_r != ST_INHIBIT);

	// Cycles since the last state change, read only by the checks below
	logic [31:0] since_r;
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i || (st_nxt != st_r))
			since_r <= 32'h0;
		else
			since_r <= since_r + 32'h1;
	end
	wire [31:0] delay_cyc_w = 32'(TRO_STROBE_DELAY_MS) * 32'(CYC_PER_MS);
	wire [31:0] hold_cyc_w  = 32'(hold_eff_w) * 32'(CYC_PER_MS);

	a_wait_after_reset: assert property (
		@(posedge core_clk_i) !rstn_i |=> (st_r == ST_WAIT) && !error_o)
		else $error("block not waiting after reset");

	a_access_on_entry: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(st_r == ST_WAIT) && tag_rise_w && !suppress_i |=> access_o)
		else $error("tag entry did not start an access");

	a_byte_presented: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		access_ok_w && !suppress_i
		|=> read_data_lines_o == $past(tag_byte_i))
		else $error("read byte not on data lines");

	a_strobe_delay: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		$rose(normal_completion_output_o)
		|-> $past(since_r) == delay_cyc_w - 32'h1)
		else $error("normal strobe not 3 ms after data");

	a_normal_hold: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		$fell(normal_completion_output_o) && !$past(suppress_i)
		&& !$past(tag_rise_w)
		|-> !$past(cont_r) && $past(since_r) == hold_cyc_w - 32'h1)
		else $error("normal output hold time wrong");

	a_suppress_clears: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		suppress_i |=> !normal_completion_output_o && !error_o)
		else $error("suppress did not clear outputs");

	a_data_stable: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		!$past(load_w) && !$past(clear_w) |-> $stable(read_data_lines_o))
		else $error("data lines changed without a result");

	a_data_zeroed: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		clear_w |=> read_data_lines_o == 8'h00)
		else $error("data lines not forced to zero");

	a_error_raised: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(st_r == ST_ACCESS) && !tag_present_i && !tag_done_i && !suppress_i
		|=> error_o && (st_r == ST_ERROR))
		else $error("early tag exit not flagged");

	a_field_stopped: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		suppress_i |-> !field_en_o ##1 !field_en_o)
		else $error("field running under suppress");

	a_continuous_hold: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		cont_r && normal_completion_output_o && !suppress_i && !tag_rise_w
		&& !(wr_w && hit_cfg_w) |=> normal_completion_output_o)
		else $error("continuous hold dropped output");

endmodule // tro_read_out

// File: tro_host_model.sv
// Host controller model that samples the byte and drives suppress
`timescale 1ns/1ps
module tro_host_model #(
	parameter int SUP_CYC = 200
) (
	input  wire logic       core_clk_i,
	input  wire logic       rstn_i,
	input  wire logic       req_i,
	input  wire logic       normal_i,
	input  wire logic [7:0] data_i,
	output logic            suppress_o,
	output logic            cap_o,
	output logic [7:0]      cap_byte_o
);
	int   cnt_r;
	logic normal_d_r;
	// Byte is registered every cycle; cap_o marks only the rise of normal completion
	always_ff @(posedge core_clk_i) begin
		normal_d_r <= normal_i;
		cap_o <= rstn_i && normal_i && !normal_d_r;
		cap_byte_o <= data_i;
		if (!rstn_i) begin
			cnt_r <= 0;
		end else if (req_i) begin
			cnt_r <= SUP_CYC;
		end else if (cnt_r != 0) begin
			cnt_r <= cnt_r - 1;
		end
	end
	// Held for the full minimum, cut short only by reset
	assign suppress_o = (cnt_r != 0);
endmodule // tro_host_model

// File: tag_read_parallel_output_tb.sv
// Self-checking testbench for the tag read parallel output block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tag_read_parallel_output_tb;
	import tro_pkg::*;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, tag_byte, rd, cap_b, b, exp_b;
	logic [31:0] pwdata, prdata, rdat;
	logic        tag_present, tag_done, field_en, access, sup;
	logic        nrm, err, irq, req, cap, rerr;
	int          errors, n_checks, cyc, seed;
	logic [7:0]  exp_q[$];
	tro_read_out #(.CYC_PER_MS(10)) dut (.core_clk_i(clk), .rstn_i(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tag_present_i(tag_present), .tag_done_i(tag_done),
		.tag_byte_i(tag_byte), .field_en_o(field_en), .access_o(access),
		.suppress_i(sup), .read_data_lines_o(rd),
		.normal_completion_output_o(nrm), .error_o(err), .irq_o(irq));
	tro_host_model #(.SUP_CYC(200)) host (.core_clk_i(clk), .rstn_i(rstn),
		.req_i(req), .normal_i(nrm), .data_i(rd), .suppress_o(sup),
		.cap_o(cap), .cap_byte_o(cap_b));
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		// Pop once: the macro names its arguments twice on a mismatch
		if (cap) begin
			exp_b = exp_q.pop_front();
			`CHK(cap_b, exp_b)
		end
		if (cyc > 5000) begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1 && cyc < 5000);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0; penable <= 0;
	endtask
	// Ends at the edge that loads the result
	task automatic tag_go(input logic ok, input logic [7:0] v);
		int n;
		@(posedge clk);
		tag_present <= 1;
		n = 0;
		do begin @(posedge clk); n++; end while (access !== 1'b1 && n < 50);
		tag_done <= ok; tag_byte <= v;
		if (!ok) tag_present <= 0;
		else exp_q.push_back(v);
		@(posedge clk);
		tag_done <= 0; tag_present <= 0;
	endtask
	task automatic inhibit();
		@(posedge clk); req <= 1;
		@(posedge clk); req <= 0;
		w(2);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
		pwdata = 0; tag_present = 0; tag_done = 0; tag_byte = 0; req = 0;
		errors = 0; n_checks = 0; cyc = 0; seed = 32'h09435127;
		repeat (3) @(posedge clk);
		rstn <= 1;
		w(2);
		`CHK({rd, nrm, err, irq, field_en, access}, 13'h002)
		apb(0, TRO_CFG_OFF, 0);
		`CHK(rdat, 32'h00000064)
		apb(0, 8'h14, 0);
		`CHK({rerr, rdat}, 33'h100000000)
		apb(1, TRO_CFG_OFF, 32'h2);
		apb(1, TRO_IRQ_EN_OFF, 32'h3);
		$display("test setup done");
		repeat (3) begin
			b = 8'($random(seed));
			tag_go(1, b);
			w(1);
			`CHK(rd, b)
			w(29);
			`CHK(nrm, 1'b0)
			w(1);
			`CHK(nrm, 1'b1)
			w(19);
			`CHK(nrm, 1'b1)
			w(2);
			`CHK({nrm, rd}, {1'b0, b})
			apb(0, TRO_IRQ_STAT_OFF, 0);
			`CHK({irq, rdat}, 33'h100000001)
			apb(1, TRO_IRQ_CLR_OFF, 32'h3);
			w(1);
			`CHK(irq, 1'b0)
		end
		$display("test reads done");
		tag_go(0, 8'h5a);
		w(1);
		`CHK({err, rd, nrm}, 10'h200)
		w(18);
		`CHK(err, 1'b1)
		w(3);
		`CHK(err, 1'b0)
		apb(1, TRO_IRQ_EN_OFF, 0);
		apb(0, TRO_IRQ_STAT_OFF, 0);
		`CHK({irq, rdat}, 33'h000000002)
		apb(1, TRO_IRQ_CLR_OFF, 32'h3);
		apb(1, TRO_IRQ_EN_OFF, 32'h3);
		$display("test error done");
		apb(1, TRO_CFG_OFF, 32'h10002);
		b = 8'($random(seed));
		tag_go(1, b);
		w(80);
		`CHK({nrm, rd}, {1'b1, b})
		inhibit();
		`CHK({nrm, rd, field_en}, 10'h000)
		w(205);
		`CHK(field_en, 1'b1)
		tag_go(0, 8'h33);
		w(80);
		`CHK(err, 1'b1)
		inhibit();
		`CHK({err, rd}, 9'h000)
		$display("test continuous done");
		tally_and_finish();
	end
endmodule // tag_read_parallel_output_tb
